/* src/sram_ctl_consts.vh */
// Purpose: Shared constants for the interleaved burst memory controller
// Assumes: Included by the controller only; the write FIFO takes its sizes as parameters
// Notes:   Definitions only, no logic
`ifndef SRAM_CTL_CONSTS_VH
`define SRAM_CTL_CONSTS_VH

// ----------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------
`define ST_IDLE       2'h0
`define ST_INSTR_ACC  2'h1
`define ST_DATA_ACC   2'h2

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
// Word counter field of the byte address
`define CNT_FIELD_LSB 2
`define CNT_FIELD_MSB 9
// Block select field
`define BLK_FIELD_LSB 10
`define BLK_FIELD_MSB 31

// ----------------------------------------------------------------
// Reset values and counter step
// ----------------------------------------------------------------
`define CNT_RST       8'h00
`define BANK_ADDR_RST 7'h00
`define CNT_ONE       8'h01

// ----------------------------------------------------------------
// Buffer defaults
// ----------------------------------------------------------------
`define WFIFO_DEPTH   16
`define WFIFO_AW      4

`endif

/* src/burst_write_fifo.v */
// Purpose: Write-word buffer between bus capture and memory write port
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read data come from a head register in front of the array
`timescale 1ns/1ps
`default_nettype none

module burst_write_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             srst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Word array
  reg [AW-1:0]    wptr_r;            // Fill pointer
  reg [AW-1:0]    rptr_r;            // Drain pointer
  reg [AW:0]      cnt_r;             // Occupancy with head, one bit wider
  reg [WIDTH-1:0] head_r;            // Head word, registered
  reg             head_v_r;          // Head word present
  wire            push;
  wire            pop;
  wire            arr_empty;         // No word behind the head
  wire            head_free;         // Head may take a new word
  wire            from_arr;          // Head refilled from the array
  wire            bypass;            // Head refilled from the fill side
  wire            to_arr;            // Word parked in the array

  // Full from the total count, so the head stage adds no room
  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = head_v_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = head_v_r & out_ready_i;
  assign out_data_o  = head_r;
  assign arr_empty   = (cnt_r == {{AW{1'b0}}, head_v_r});
  assign head_free   = ~head_v_r | pop;
  assign from_arr    = head_free & ~arr_empty;
  // Empty array and free head: word goes straight to the head, no added latency
  assign bypass      = head_free & arr_empty & push;
  assign to_arr      = push & ~bypass;

  // Array write, no reset needed for data
  always @(posedge clk_i)
  begin
    if (to_arr)
    begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  // Head register, so read data always leave a flip-flop
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      head_r   <= {WIDTH{1'b0}};
      head_v_r <= 1'b0;
    end
    else if (from_arr)
    begin
      // Oldest parked word moves up
      head_r   <= mem_r[rptr_r];
      head_v_r <= 1'b1;
    end
    else if (bypass)
    begin
      head_r   <= in_data_i;
      head_v_r <= 1'b1;
    end
    else if (pop)
    begin
      head_v_r <= 1'b0;
    end
  end

  // Pointer and count update
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (to_arr)
      begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (from_arr)
      begin
        rptr_r <= rptr_r + 1'b1;
      end
      // Simultaneous push and pop leave the count alone
      if (push & ~pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // burst_write_fifo
`default_nettype wire

/* src/interleaved_sram_burst_control.v */
// Purpose: Burst controller for a two-bank odd/even interleaved memory
// Assumes: Instruction and data requests share one address bus
// Notes:   Write words are buffered before the memory write port
//
// Behaviour
// - Instruction hit raises selected same cycle
// - Decode cycle asserts counter load
// - First read word ends third cycle
// - Advance when delayed burst and ack
// - Ready with every valid read word
// - Bank enables alternate, even first from an even start
// - Eight-bit counter, upper seven address memory
// - Delayed burst low drops ready
// - Suspension holds counter, no advance
// - Resumption restores ready and counting
// - Odd start reverses order, even bumped
// - Write words taken one cycle earlier
// - Writes enable data registers, write enables
// - Data hit raises data selected
// - Data access preempts instruction burst
// - Preempt cycle gives last word, loads
// - Non-burst data access moves one word
// - Request without burst returns to idle
// - Re-entry acks, counts, word next cycle
// - Data-only use ties instruction inputs off
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctl_consts.vh"

module interleaved_sram_burst_control #(
  parameter          DW        = 32,
  parameter          DATA_ONLY = 0,
  parameter [21:0]   BLK_BASE  = 22'h00_0000
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          srst_i,
  // Processor address and direction
  input  wire [31:0]   addr_i,
  input  wire          rw_i,
  input  wire [DW-1:0] wdata_i,
  // Processor requests
  input  wire          instr_request_i,
  input  wire          instr_burst_request_i,
  input  wire          data_request_i,
  input  wire          data_burst_request_i,
  // Decode results
  output wire          instr_block_selected_o,
  output wire          data_block_selected_o,
  // Responses
  output wire          instr_burst_ack_o,
  output wire          data_burst_ack_o,
  output wire          instr_ready_o,
  output wire          data_ready_o,
  // Counter control
  output wire          counter_load_o,
  output wire          counter_advance_o,
  // Bank read side
  output wire          instr_even_bank_out_enable_o,
  output wire          instr_odd_bank_out_enable_o,
  output wire          data_even_bank_out_enable_o,
  output wire          data_odd_bank_out_enable_o,
  output reg  [6:0]    even_bank_addr_o,
  output reg  [6:0]    odd_bank_addr_o,
  // Bank write side
  output wire          write_data_reg_enable_even_o,
  output wire          write_data_reg_enable_odd_o,
  output wire          write_enable_even_o,
  output wire          write_enable_odd_o,
  output reg  [6:0]    write_addr_o,
  output reg  [DW-1:0] write_data_o,
  input  wire          write_ready_i
);

  // ----------------------------------------------------------------
  // Block decode
  // ----------------------------------------------------------------
  // Shared by both request paths
  function in_block;
    input [31:0] a;
    begin
      in_block = (a[`BLK_FIELD_MSB:`BLK_FIELD_LSB] == BLK_BASE);
    end
  endfunction

  localparam FW = DW + 8; // Buffered word: bank, address, data

  // Qualified instruction inputs
  wire instr_request;
  wire instr_burst_request;
  assign instr_request  = (DATA_ONLY == 0) & instr_request_i;
  assign instr_burst_request = (DATA_ONLY == 0) & instr_burst_request_i;

  wire isel; // Instruction hit
  wire dsel; // Data hit
  assign isel = instr_request & in_block(addr_i);
  assign dsel = data_request_i & in_block(addr_i);

  assign instr_block_selected_o = isel;
  assign data_block_selected_o  = dsel;

  // ----------------------------------------------------------------
  // State and bookkeeping registers
  // ----------------------------------------------------------------
  reg [1:0] state_r;   // Access state
  reg [1:0] state_nxt; // Next access state
  reg       instr_burst_request_delayed_r; // Instruction burst request, delayed
  reg       data_burst_request_d_r; // Data burst request, delayed
  reg [7:0] cnt_r;     // Memory address counter
  reg [7:0] cnt_nxt;   // Next counter value
  reg [7:0] wptr_r;    // Word now on the bus
  reg       rw_r;      // Direction of current access
  reg       primed_r;  // First access cycle has passed
  reg       first_r;   // First word still pending

  wire iacc;
  wire dacc;
  wire acc;
  wire breq_now;
  wire breq_d;
  wire preempt;
  wire load;
  wire adv;
  wire rd_word;
  wire take;
  wire xfer;
  wire done;
  wire fifo_in_ready;

  assign iacc = (state_r == `ST_INSTR_ACC);
  assign dacc = (state_r == `ST_DATA_ACC);
  assign acc  = iacc | dacc;

  // Burst request of the running access
  assign breq_now = dacc ? data_burst_request_i : instr_burst_request;
  assign breq_d   = dacc ? data_burst_request_d_r : instr_burst_request_delayed_r;

  assign preempt = iacc & dsel;

  assign load = ((state_r == `ST_IDLE) & (isel | dsel)) | preempt;

  // advance on delayed burst and ack
  assign adv = acc & breq_d & ~load;

  // first read word after priming cycle
  assign rd_word = acc & rw_r & primed_r & (first_r | breq_d);

  // write word one cycle before a read
  // Full buffer stalls the word and its ready
  assign take = acc & ~rw_r & (first_r | breq_d) & fifo_in_ready;
  assign xfer = rd_word | take;

  // exit once no further burst word is due
  // One quiet request cycle is a suspension; a second ends the burst
  assign done = ~breq_now & ~breq_d & (xfer | ~first_r);

  // ----------------------------------------------------------------
  // Response outputs
  // ----------------------------------------------------------------
  assign instr_burst_ack_o = iacc;
  assign data_burst_ack_o  = dacc;
  assign counter_load_o    = load;
  assign counter_advance_o = adv;

  assign instr_ready_o = iacc & rd_word;
  assign data_ready_o  = dacc & xfer;

  // odd start enables odd bank first
  assign instr_even_bank_out_enable_o = iacc & rd_word & ~wptr_r[0];
  assign instr_odd_bank_out_enable_o  = iacc & rd_word & wptr_r[0];
  assign data_even_bank_out_enable_o  = dacc & rd_word & ~wptr_r[0];
  assign data_odd_bank_out_enable_o   = dacc & rd_word & wptr_r[0];

  assign write_data_reg_enable_even_o = take & ~wptr_r[0];
  assign write_data_reg_enable_odd_o  = take & wptr_r[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Data wins when both sides hit in the same cycle
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE:
      begin
        // Decode straight into the matching access
        if (dsel)
        begin
          state_nxt = `ST_DATA_ACC;
        end
        else if (isel)
        begin
          state_nxt = `ST_INSTR_ACC;
        end
      end
      `ST_INSTR_ACC:
      begin
        // ack drops as data takes over
        if (preempt)
        begin
          state_nxt = `ST_DATA_ACC;
        end
        else if (done)
        begin
          state_nxt = `ST_IDLE;
        end
      end
      `ST_DATA_ACC:
      begin
        // back to idle after last word
        if (done)
        begin
          state_nxt = `ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = `ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  // Load beats advance; the word field is the counter
  always @*
  begin
    cnt_nxt = cnt_r;
    if (load)
    begin
      cnt_nxt = addr_i[`CNT_FIELD_MSB:`CNT_FIELD_LSB];
    end
    else if (adv)
    begin
      cnt_nxt = cnt_r + `CNT_ONE;
    end
  end

  // Bank addresses drawn from the counter
  wire [7:0] cnt_up;
  assign cnt_up = cnt_nxt + `CNT_ONE;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // everything idle and cleared on reset
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r          <= `ST_IDLE;
      instr_burst_request_delayed_r        <= 1'b0;
      data_burst_request_d_r        <= 1'b0;
      cnt_r            <= `CNT_RST;
      wptr_r           <= `CNT_RST;
      rw_r             <= 1'b0;
      primed_r         <= 1'b0;
      first_r          <= 1'b0;
      even_bank_addr_o <= `BANK_ADDR_RST;
      odd_bank_addr_o  <= `BANK_ADDR_RST;
    end
    else
    begin
      state_r   <= state_nxt;
      // Delayed burst requests, one cycle behind the bus
      instr_burst_request_delayed_r <= instr_burst_request;
      data_burst_request_d_r <= data_burst_request_i;
      cnt_r     <= cnt_nxt;
      // lsb steers, upper seven address memory
      // even bank moves to next even word
      odd_bank_addr_o  <= cnt_nxt[7:1];
      even_bank_addr_o <= cnt_up[7:1];
      if (load)
      begin
        wptr_r   <= addr_i[`CNT_FIELD_MSB:`CNT_FIELD_LSB];
        rw_r     <= rw_i;
        primed_r <= 1'b0;
        first_r  <= 1'b1;
      end
      else
      begin
        // word follows one cycle after re-entry
        if (acc)
        begin
          primed_r <= 1'b1;
        end
        if (xfer)
        begin
          wptr_r  <= wptr_r + `CNT_ONE;
          first_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write buffering
  // ----------------------------------------------------------------
  // Bus captures decoupled from memory write timing
  wire          fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire          drain;
  reg           wv_r;   // Write word held at memory port
  reg           wbank_r; // Bank of held word

  burst_write_fifo #(
    .WIDTH (FW),
    .DEPTH (`WFIFO_DEPTH),
    .AW    (`WFIFO_AW)
  ) u_wfifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (take),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({wptr_r[0], wptr_r[7:1], wdata_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain),
    .out_data_o  (fifo_out_data)
  );

  // Refill the port stage when empty or accepted
  assign drain = fifo_out_valid & (~wv_r | write_ready_i);

  assign write_enable_even_o = wv_r & ~wbank_r;
  assign write_enable_odd_o  = wv_r & wbank_r;

  // Memory write port stage
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wv_r         <= 1'b0;
      wbank_r      <= 1'b0;
      write_addr_o <= `BANK_ADDR_RST;
      write_data_o <= {DW{1'b0}};
    end
    else if (drain)
    begin
      wv_r         <= 1'b1;
      wbank_r      <= fifo_out_data[FW-1];
      write_addr_o <= fifo_out_data[FW-2:DW];
      write_data_o <= fifo_out_data[DW-1:0];
    end
    else if (write_ready_i)
    begin
      // Held word written, port now empty
      wv_r <= 1'b0;
    end
  end

endmodule // interleaved_sram_burst_control
`default_nettype wire

/* verif/sram_ctl_sva.sv */
// Purpose: Port checks for the interleaved burst controller
// Assumes: Default BLK_BASE match on addr_i[31:10]
// Notes:   Timing follows the controller's request protocol
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_chk #(
  parameter [21:0] BLK_BASE = 22'h00_0000
) (
  // Clock, reset, bus
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [31:0] addr_i,
  input wire logic        rw_i,
  input wire logic        instr_request_i,
  input wire logic        instr_burst_request_i,
  input wire logic        data_request_i,
  input wire logic        data_burst_request_i,
  // Controller outputs
  input wire logic        instr_block_selected_o,
  input wire logic        data_block_selected_o,
  input wire logic        instr_burst_ack_o,
  input wire logic        data_burst_ack_o,
  input wire logic        instr_ready_o,
  input wire logic        data_ready_o,
  input wire logic        counter_load_o,
  input wire logic        counter_advance_o,
  input wire logic        instr_even_bank_out_enable_o,
  input wire logic        instr_odd_bank_out_enable_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire hit = (addr_i[31:10] == BLK_BASE);  // Block decode
  wire ie  = instr_even_bank_out_enable_o; // Even bank drive
  wire io  = instr_odd_bank_out_enable_o;  // Odd bank drive
  // New instruction access decoded from idle
  wire inew = counter_load_o && instr_block_selected_o && !instr_burst_ack_o && !data_burst_ack_o;
  AST_ISEL: assert property (instr_block_selected_o == (instr_request_i && hit))
    else $error("instr select wrong");
  AST_DSEL: assert property (data_block_selected_o == (data_request_i && hit))
    else $error("data select wrong");
  AST_FIRST: assert property (inew && rw_i && instr_burst_request_i |=> !instr_ready_o ##1 instr_ready_o)
    else $error("first word late");
  AST_ADV: assert property (counter_advance_o == (!counter_load_o
    && (instr_burst_ack_o && $past(instr_burst_request_i) || data_burst_ack_o && $past(data_burst_request_i))))
    else $error("advance wrong");
  AST_SUSP: assert property (instr_burst_ack_o && $past(instr_ready_o) && !$past(instr_burst_request_i)
    |-> !instr_ready_o)
    else $error("ready in suspension");
  AST_IOE: assert property ((instr_ready_o == (ie || io)) && !(ie && io))
    else $error("bank enable wrong");
  AST_PRE: assert property (instr_burst_ack_o && data_block_selected_o |-> counter_load_o
    ##1 (!instr_burst_ack_o && data_burst_ack_o))
    else $error("preempt wrong");
  AST_ONE: assert property (counter_load_o && data_block_selected_o && !data_burst_ack_o && rw_i
    && !data_burst_request_i |=> data_burst_ack_o && !data_ready_o ##1 data_ready_o ##1 !data_burst_ack_o)
    else $error("single data read wrong");
  // Main scenarios reached
  COV_RESUME: cover property (instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o);
  COV_PRE: cover property (instr_burst_ack_o && data_block_selected_o);
  COV_ONE: cover property (data_burst_ack_o && data_ready_o && rw_i);
endmodule // sram_ctl_chk
bind interleaved_sram_burst_control sram_ctl_chk #(.BLK_BASE(BLK_BASE)) u_chk (.clk_i, .srst_i, .addr_i, .rw_i,
  .instr_request_i, .instr_burst_request_i, .data_request_i, .data_burst_request_i, .instr_block_selected_o,
  .data_block_selected_o, .instr_burst_ack_o, .data_burst_ack_o, .instr_ready_o, .data_ready_o, .counter_load_o,
  .counter_advance_o, .instr_even_bank_out_enable_o, .instr_odd_bank_out_enable_o);
`default_nettype wire

/* verif/mem_write_sink.sv */
// Purpose: Memory write port model, logs every accepted word
// Assumes: One word per cycle when not stalled
// Notes:   Stall lets the bench back up the write buffer
`timescale 1ns/1ps
`default_nettype none
module mem_write_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Write port
  input  wire logic        we_even_i,
  input  wire logic        we_odd_i,
  input  wire logic [6:0]  addr_i,
  input  wire logic [31:0] data_i,
  input  wire logic        stall_i,
  output wire logic        ready_o
);
  logic [39:0] got [$]; // Bank, address, data as accepted
  assign ready_o = !stall_i;
  // Log on handshake only
  always @(posedge clk_i)
    if (!srst_i && ready_o && (we_even_i || we_odd_i))
      got.push_back({we_odd_i, addr_i, data_i});
endmodule // mem_write_sink
`default_nettype wire

/* verif/tb.sv */
// Purpose: Scenario bench for the interleaved burst controller
// Assumes: BLK_BASE zero, bus driven on rising edges
// Notes:   Outputs sampled 1 ns after each edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, srst_i = 1, rw = 1, instr_request = 0, instr_burst_request = 0, data_request = 0, data_burst_request = 0, stall = 0;
  logic [31:0] addr = 0, wdata = 0;
  wire isel, dsel, iack, dack, instr_ready, data_ready, ld, adv, ie, io, de, dd, w0, w1, we0, we1, wrdy;
  wire [6:0] ea, oa, wa;
  wire [31:0] wd;
  int err_count = 0, checks = 0;
  always #2.5 clk_i = ~clk_i;
  interleaved_sram_burst_control u_interleaved_sram_burst_control (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr),
    .rw_i(rw), .wdata_i(wdata), .instr_request_i(instr_request), .instr_burst_request_i(instr_burst_request), .data_request_i(data_request),
    .data_burst_request_i(data_burst_request), .instr_block_selected_o(isel), .data_block_selected_o(dsel),
    .instr_burst_ack_o(iack), .data_burst_ack_o(dack), .instr_ready_o(instr_ready), .data_ready_o(data_ready),
    .counter_load_o(ld), .counter_advance_o(adv), .instr_even_bank_out_enable_o(ie),
    .instr_odd_bank_out_enable_o(io), .data_even_bank_out_enable_o(de), .data_odd_bank_out_enable_o(dd),
    .even_bank_addr_o(ea), .odd_bank_addr_o(oa), .write_data_reg_enable_even_o(w0),
    .write_data_reg_enable_odd_o(w1), .write_enable_even_o(we0), .write_enable_odd_o(we1),
    .write_addr_o(wa), .write_data_o(wd), .write_ready_i(wrdy));
  mem_write_sink u_sink (.clk_i(clk_i), .srst_i(srst_i), .we_even_i(we0), .we_odd_i(we1), .addr_i(wa),
    .data_i(wd), .stall_i(stall), .ready_o(wrdy));
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_idle;
    int n;
    for (n = 0; n < 20 && (iack || dack); n++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("idle", iack | dack, 0);
  endtask
  // Burst read with one suspension; odd start reverses bank order
  task instr_read(input logic [31:0] a);
    @(posedge clk_i); instr_request <= 1; instr_burst_request <= 1; rw <= 1; addr <= a;
    #1 chk("isel", isel, 1);
    chk("load", ld, 1);
    @(posedge clk_i); instr_request <= 0;
    #1 chk("adv", adv, 1);
    chk("irdy2", instr_ready, 0);
    chk("odd addr", oa, a[9:3]);
    chk("even addr", ea, a[9:3] + a[2]);
    @(posedge clk_i);
    #1 chk("irdy3", instr_ready, 1);
    chk("ie3", ie, !a[2]);
    chk("io3", io, a[2]);
    @(posedge clk_i);
    #1 chk("ie4", ie, a[2]);
    @(posedge clk_i); instr_burst_request <= 0;
    #1 chk("irdy5", instr_ready, 1);
    @(posedge clk_i); instr_burst_request <= 1;
    #1 chk("irdy6", instr_ready, 0);
    chk("adv6", adv, 0);
    @(posedge clk_i); instr_burst_request <= 0;
    #1 chk("irdy7", instr_ready, 1);
    chk("adv7", adv, 1);
    chk("ie7", ie, a[2]);
    wait_idle;
  endtask
  // Data read cuts an instruction burst, then the fetch restarts
  task preempt;
    @(posedge clk_i); instr_request <= 1; instr_burst_request <= 1; rw <= 1; addr <= 32'h0000_0040;
    @(posedge clk_i); instr_request <= 0;
    @(posedge clk_i); data_request <= 1; addr <= 32'h0000_0084;
    #1 chk("dsel", dsel, 1);
    chk("load pre", ld, 1);
    chk("instr_ready pre", instr_ready, 1);
    @(posedge clk_i); instr_burst_request <= 0;
    #1 chk("iack pre", iack, 0);
    chk("dack", dack, 1);
    @(posedge clk_i); data_request <= 0; instr_request <= 1; instr_burst_request <= 1; addr <= 32'h0000_0048;
    #1 chk("data_ready", data_ready, 1);
    chk("dd", dd, 1);
    chk("de", de, 0);
    @(posedge clk_i);
    #1 chk("dack end", dack, 0);
    chk("reload", ld, 1);
    @(posedge clk_i); instr_request <= 0;
    #1 chk("iack re", iack, 1);
    chk("adv re", adv, 1);
    @(posedge clk_i); instr_burst_request <= 0;
    #1 chk("instr_ready re", instr_ready, 1);
    wait_idle;
  endtask
  // Write burst into a stalled port until the buffer refuses
  task write_burst;
    logic [39:0] q [$];
    logic [31:0] n;
    logic [7:0] w;
    logic r, full;
    int k;
    n = 0;
    full = 0;
    @(posedge clk_i); data_request <= 1; data_burst_request <= 1; rw <= 0; addr <= 32'h0000_0108; wdata <= 32'h1000_0000; stall <= 1;
    #1 chk("dsel w", dsel, 1);
    @(posedge clk_i); data_request <= 0;
    #1 chk("wreg c2", w0, 1);
    for (k = 0; k < 90 && dack; k++)
    begin
      r = data_ready;
      if (r)
      begin
        w = 8'h42 + n[7:0];
        chk("wreg", {w1, w0}, {w[0], !w[0]});
        q.push_back({w[0], w[7:1], 32'h1000_0000 + n});
        n++;
      end
      else if (data_burst_request)
        full = 1;
      @(posedge clk_i);
      if (r) wdata <= wdata + 1;
      if (n >= 20) data_burst_request <= 0;
      if (k == 40) stall <= 0;
      #1;
    end
    chk("full", full, 1);
    for (k = 0; k < 60 && u_sink.got.size() < q.size(); k++) @(posedge clk_i);
    chk("words", u_sink.got.size(), q.size());
    foreach (q[i]) chk("word", u_sink.got[i], q[i]);
    rw <= 1;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    srst_i <= 0;
    instr_read(32'h0000_0010);
    instr_read(32'h0000_0034);
    preempt;
    write_burst;
    complete_run;
  end
  // Hang guard, far beyond the scenario length
  initial
  begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    complete_run;
  end
endmodule // tb
`default_nettype wire
